// file: core/ftlv_defines.vh
`ifndef FTLV_DEFINES_VH
`define FTLV_DEFINES_VH

// Output depth selection
`define FTLV_MODE_12BIT      2'h0
`define FTLV_MODE_10BIT      2'h1
`define FTLV_MODE_8BIT       2'h2

// Sample and tap geometry
`define FTLV_SAMPLE_W        12
`define FTLV_TAPS            4
`define FTLV_PORT_W          8

// Line lengths in pixels at full resolution
`define FTLV_PIX_LARGE       13'h1000
`define FTLV_PIX_SMALL       13'h0800

// Buffer shape
`define FTLV_FIFO_DEPTH      32
`define FTLV_FIFO_AW         5

// Line word counter width
`define FTLV_WORD_W          11

// Unused output level
`define FTLV_UNUSED_LEVEL    1'b0

`endif

// file: core/ftlv_video_out.v
// Summary of operation
// [RULE1] 12-bit mode: four 12-bit pixels plus flags
// [RULE2] Output only on transmitters X and Y
// [RULE3] New word on each pixel clock rise
// [RULE4] Receiver takes data when both flags high
// [RULE5] 10-bit mode drops two low bits
// [RULE6] 8-bit mode drops four low bits
// [RULE7] Idle: both flags low every cycle
// [RULE8] Start line only after readout completes
// [RULE9] First cycle: flags rise, pixels 1-4
// [RULE10] Later cycles advance taps by four pixels
// [RULE11] After last pixels both flags drop
// [RULE12] 12-bit bit map on transmitter X
// [RULE13] 10-bit bit map on transmitter X
// [RULE14] 8-bit bit map on transmitter X
// [RULE15] Transmitter Y carries taps three, two (8-bit mode puts only tap three on Y port D, tap two goes on X port C)
// [RULE16] Line length from model, binning, AOI
// [RULE17] Unused outputs driven constant low
`include "ftlv_defines.vh"

module ftlv_fifo #(
  parameter WIDTH = 48,
  parameter DEPTH = `FTLV_FIFO_DEPTH,
  parameter AW    = `FTLV_FIFO_AW
) (
  // Clock and reset
  input  wire             sys_clk,
  input  wire             reset,
  // Fill side
  input  wire             in_valid,
  output wire             in_ready,
  input  wire [WIDTH-1:0] in_data,
  // Drain side
  output wire             out_valid,
  input  wire             out_ready,
  output wire [WIDTH-1:0] out_data
);
  localparam [AW:0] DEPTH_CNT = DEPTH;
  reg [WIDTH-1:0] mem_reg [0:DEPTH-1];
  reg [AW-1:0]    wr_ptr_reg;
  reg [AW-1:0]    rd_ptr_reg;
  reg [AW:0]      count_reg;
  reg [AW:0]      count_next;
  reg             ready_reg;
  reg             empty_reg;
  wire            push;
  wire            pop;
  // Ready straight from a flop, low in reset
  assign in_ready  = ready_reg;
  assign out_valid = ~empty_reg;
  assign out_data  = mem_reg[rd_ptr_reg];
  assign push      = in_valid & ready_reg;
  assign pop       = out_ready & ~empty_reg;
  always @* begin
    count_next = count_reg;
    if (push & ~pop) begin
      count_next = count_reg + 1'b1;
    end else if (pop & ~push) begin
      count_next = count_reg - 1'b1;
    end
  end

  always @(posedge sys_clk) begin
    if (push) begin
      mem_reg[wr_ptr_reg] <= in_data;
    end
  end
  always @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      wr_ptr_reg <= {AW{1'b0}};
      rd_ptr_reg <= {AW{1'b0}};
      count_reg  <= {(AW+1){1'b0}};
      ready_reg  <= 1'b0;
      empty_reg  <= 1'b1;
    end else begin
      if (push) begin
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
      end
      count_reg <= count_next;
      ready_reg <= (count_next != DEPTH_CNT);
      empty_reg <= (count_next == {(AW+1){1'b0}});
    end
  end

endmodule // ftlv_fifo
module ftlv_video_out (
  // Clock and reset
  input  wire        sys_clk,
  input  wire        reset,
  // Link pixel clock from the outside
  input  wire        pix_clk,
  // Line configuration
  input  wire [1:0]  depth_mode,
  input  wire        model_large,
  input  wire        hbin_en,
  input  wire        aoi_en,
  input  wire [12:0] aoi_pixels,
  // Sensor readout
  input  wire        readout_done,
  input  wire        sample_valid,
  output wire        sample_ready,
  input  wire [47:0] sample_data,
  // Transmitter X
  output reg  [7:0]  tx_x_port_a_reg,
  output reg  [7:0]  tx_x_port_b_reg,
  output reg  [7:0]  tx_x_port_c_reg,
  output reg         tx_x_lval_reg,
  output reg         tx_x_fval_reg,
  output reg         tx_x_dval_reg,
  output reg         tx_x_spare_reg,
  output reg         tx_x_clk_reg,
  // Transmitter Y
  output reg  [7:0]  tx_y_port_d_reg,
  output reg  [7:0]  tx_y_port_e_reg,
  output reg  [7:0]  tx_y_port_f_reg,
  output reg         tx_y_lval_reg,
  output reg         tx_y_fval_reg,
  output reg         tx_y_dval_reg,
  output reg         tx_y_spare_reg,
  output reg         tx_y_clk_reg,
  // Line status
  output reg         line_busy_reg
);
  localparam ST_IDLE   = 2'h0;
  localparam ST_ACTIVE = 2'h1;
  reg        pclk_meta_reg;
  reg        pclk_sync_reg;
  reg        pclk_prev_reg;
  wire       pix_rise;
  reg [1:0]  state_reg;
  reg [1:0]  mode_reg;
  reg        pending_reg;
  reg        started_reg;
  reg [`FTLV_WORD_W-1:0] words_left_reg;
  reg [12:0] line_pixels;
  wire [`FTLV_WORD_W-1:0] line_words;
  wire       fifo_valid;
  wire       fifo_pop;
  wire [47:0] fifo_data;
  wire       line_start;
  wire       send_word;
  wire       line_done;
  wire [11:0] tap_stream_zero;
  wire [11:0] tap_stream_one;
  wire [11:0] tap_stream_two;
  wire [11:0] tap_stream_three;
  reg  [7:0]  map_a;
  reg  [7:0]  map_b;
  reg  [7:0]  map_c;
  reg  [7:0]  map_d;
  reg  [7:0]  map_e;
  reg  [7:0]  map_f;
  // Pixel clock synchroniser and rise detect
  always @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      pclk_meta_reg <= 1'b0;
      pclk_sync_reg <= 1'b0;
      pclk_prev_reg <= 1'b0;
    end else begin
      pclk_meta_reg <= pix_clk;
      pclk_sync_reg <= pclk_meta_reg;
      pclk_prev_reg <= pclk_sync_reg;
    end
  end
  assign pix_rise = pclk_sync_reg & ~pclk_prev_reg; // [RULE3]
  // Line length selection
  always @* begin
    line_pixels = model_large ? `FTLV_PIX_LARGE : `FTLV_PIX_SMALL; // [RULE16]
    if (hbin_en) begin
      line_pixels = {1'b0, line_pixels[12:1]}; // [RULE16]
    end
    if (aoi_en) begin
      line_pixels = aoi_pixels; // [RULE16]
    end
  end
  assign line_words = line_pixels[12:2];
  ftlv_fifo #(
    .WIDTH (48),
    .DEPTH (`FTLV_FIFO_DEPTH),
    .AW    (`FTLV_FIFO_AW)
  ) u_fifo (
    .sys_clk   (sys_clk),
    .reset     (reset),
    .in_valid  (sample_valid),
    .in_ready  (sample_ready),
    .in_data   (sample_data),
    .out_valid (fifo_valid),
    .out_ready (fifo_pop),
    .out_data  (fifo_data)
  );
  assign line_start = (state_reg == ST_IDLE) & (pending_reg | readout_done); // [RULE8]
  assign line_done  = (words_left_reg == {`FTLV_WORD_W{1'b0}});
  assign send_word  = (state_reg == ST_ACTIVE) & pix_rise & fifo_valid & ~line_done;
  assign fifo_pop   = send_word;
  // Taps: pixel 4k+1 on tap zero through 4k+4 on tap three
  assign tap_stream_zero  = fifo_data[11:0];  // [RULE9]
  assign tap_stream_one   = fifo_data[23:12]; // [RULE9]
  assign tap_stream_two   = fifo_data[35:24]; // [RULE9]
  assign tap_stream_three = fifo_data[47:36]; // [RULE9]
  // Bit mapping onto transmitter ports
  always @* begin
    case (mode_reg)
      `FTLV_MODE_12BIT: begin
        map_a = tap_stream_zero[7:0];                                   // [RULE12]
        map_b = {tap_stream_one[11:8], tap_stream_zero[11:8]};          // [RULE12]
        map_c = tap_stream_one[7:0];                                    // [RULE12]
        map_d = tap_stream_three[7:0];                                  // [RULE15]
        map_e = tap_stream_two[7:0];                                    // [RULE15]
        map_f = {tap_stream_three[11:8], tap_stream_two[11:8]};         // [RULE15] [RULE1]
      end
      `FTLV_MODE_10BIT: begin
        map_a = tap_stream_zero[9:2];                                   // [RULE5] [RULE13]
        map_b = {2'h0, tap_stream_one[11:10], 2'h0, tap_stream_zero[11:10]}; // [RULE13]
        map_c = tap_stream_one[9:2];                                    // [RULE13]
        map_d = tap_stream_three[9:2];                                  // [RULE15]
        map_e = tap_stream_two[9:2];                                    // [RULE15]
        map_f = {2'h0, tap_stream_three[11:10], 2'h0, tap_stream_two[11:10]}; // [RULE15]
      end
      `FTLV_MODE_8BIT: begin
        map_a = tap_stream_zero[11:4];                                  // [RULE6] [RULE14]
        map_b = tap_stream_one[11:4];                                   // [RULE14]
        map_c = tap_stream_two[11:4];                                   // [RULE14]
        map_d = tap_stream_three[11:4];                                 // [RULE15]
        map_e = 8'h00;                                                  // [RULE17]
        map_f = 8'h00;                                                  // [RULE17]
      end
      default: begin
        map_a = 8'h00;
        map_b = 8'h00;
        map_c = 8'h00;
        map_d = 8'h00;
        map_e = 8'h00;
        map_f = 8'h00;
      end
    endcase
  end
  // Line sequencer
  always @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      state_reg      <= ST_IDLE;
      mode_reg       <= `FTLV_MODE_12BIT;
      pending_reg    <= 1'b0;
      started_reg    <= 1'b0;
      words_left_reg <= {`FTLV_WORD_W{1'b0}};
      line_busy_reg  <= 1'b0;
    end else begin
      if (readout_done & (~line_start | pending_reg)) begin
        pending_reg <= 1'b1;
      end else if (line_start) begin
        pending_reg <= 1'b0;
      end
      case (state_reg)
        ST_IDLE: begin
          if (line_start) begin
            state_reg      <= ST_ACTIVE; // [RULE8]
            mode_reg       <= depth_mode;
            words_left_reg <= line_words; // [RULE16]
            started_reg    <= 1'b0;
            line_busy_reg  <= 1'b1;
          end
        end
        ST_ACTIVE: begin
          if (send_word) begin
            words_left_reg <= words_left_reg - 1'b1; // [RULE10]
            started_reg    <= 1'b1;
          end else if (pix_rise & line_done) begin
            state_reg     <= ST_IDLE; // [RULE11]
            started_reg   <= 1'b0;
            line_busy_reg <= 1'b0;
          end
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end
  // Transmitter registers, updated on pixel clock rise
  always @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      tx_x_port_a_reg <= 8'h00;
      tx_x_port_b_reg <= 8'h00;
      tx_x_port_c_reg <= 8'h00;
      tx_x_lval_reg   <= 1'b0;
      tx_x_dval_reg   <= 1'b0;
      tx_y_port_d_reg <= 8'h00;
      tx_y_port_e_reg <= 8'h00;
      tx_y_port_f_reg <= 8'h00;
      tx_y_lval_reg   <= 1'b0;
      tx_y_dval_reg   <= 1'b0;
    end else if (pix_rise) begin // [RULE3]
      if (send_word) begin
        tx_x_port_a_reg <= map_a; // [RULE2]
        tx_x_port_b_reg <= map_b;
        tx_x_port_c_reg <= map_c;
        tx_y_port_d_reg <= map_d; // [RULE2]
        tx_y_port_e_reg <= map_e;
        tx_y_port_f_reg <= map_f;
        tx_x_lval_reg   <= 1'b1; // [RULE9] [RULE10]
        tx_x_dval_reg   <= 1'b1; // [RULE4]
        tx_y_lval_reg   <= 1'b1; // [RULE15]
        tx_y_dval_reg   <= 1'b1;
      end else begin
        tx_x_port_a_reg <= 8'h00;
        tx_x_port_b_reg <= 8'h00;
        tx_x_port_c_reg <= 8'h00;
        tx_y_port_d_reg <= 8'h00;
        tx_y_port_e_reg <= 8'h00;
        tx_y_port_f_reg <= 8'h00;
        // Underrun inside a line keeps line valid, drops data valid
        tx_x_lval_reg   <= (state_reg == ST_ACTIVE) & started_reg & ~line_done; // [RULE7] [RULE11]
        tx_y_lval_reg   <= (state_reg == ST_ACTIVE) & started_reg & ~line_done; // [RULE7] [RULE11]
        tx_x_dval_reg   <= 1'b0; // [RULE7]
        tx_y_dval_reg   <= 1'b0; // [RULE7]
      end
    end
  end
  // Pixel clock forwarding and unused bits
  always @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      tx_x_clk_reg   <= 1'b0;
      tx_y_clk_reg   <= 1'b0;
      tx_x_fval_reg  <= `FTLV_UNUSED_LEVEL;
      tx_y_fval_reg  <= `FTLV_UNUSED_LEVEL;
      tx_x_spare_reg <= `FTLV_UNUSED_LEVEL;
      tx_y_spare_reg <= `FTLV_UNUSED_LEVEL;
    end else begin
      tx_x_clk_reg   <= pclk_prev_reg; // [RULE2]
      tx_y_clk_reg   <= pclk_prev_reg; // [RULE15]
      tx_x_fval_reg  <= `FTLV_UNUSED_LEVEL; // [RULE17]
      tx_y_fval_reg  <= `FTLV_UNUSED_LEVEL; // [RULE17]
      tx_x_spare_reg <= `FTLV_UNUSED_LEVEL; // [RULE17]
      tx_y_spare_reg <= `FTLV_UNUSED_LEVEL; // [RULE17]
    end
  end
endmodule // ftlv_video_out

// file: bench/ftlv_video_out_asserts.sv
module ftlv_chk (
  // Clock and reset
  input logic       sys_clk,
  input logic       reset,
  // Inputs watched
  input logic [1:0] depth_mode,
  input logic       readout_done,
  // Outputs watched
  input logic [7:0] tx_x_port_a_reg,
  input logic [7:0] tx_x_port_b_reg,
  input logic [7:0] tx_y_port_e_reg,
  input logic [7:0] tx_y_port_f_reg,
  input logic       tx_x_lval_reg,
  input logic       tx_x_dval_reg,
  input logic       tx_x_fval_reg,
  input logic       tx_x_spare_reg,
  input logic       tx_y_lval_reg,
  input logic       tx_y_dval_reg,
  input logic       tx_y_fval_reg,
  input logic       tx_y_spare_reg,
  input logic       tx_x_clk_reg,
  input logic       tx_y_clk_reg,
  input logic       line_busy_reg
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);
  property p_rise; $rose(tx_x_lval_reg) |-> tx_x_dval_reg; endproperty
  a_rise: assert property (p_rise) else $error("lval rose alone");
  property p_fall; $fell(tx_x_lval_reg) |-> !tx_x_dval_reg && !line_busy_reg; endproperty
  a_fall: assert property (p_fall) else $error("flags did not drop together");
  property p_yrep; tx_y_lval_reg == tx_x_lval_reg && tx_y_dval_reg == tx_x_dval_reg; endproperty
  a_yrep: assert property (p_yrep) else $error("Y flags differ");
  property p_unused; !(tx_x_fval_reg | tx_x_spare_reg | tx_y_fval_reg | tx_y_spare_reg);
  endproperty
  a_unused: assert property (p_unused) else $error("unused bit high");
  property p_idle; !line_busy_reg |-> !tx_x_lval_reg && !tx_x_dval_reg; endproperty
  a_idle: assert property (p_idle) else $error("flags high while idle");
  property p_m8; tx_x_dval_reg && depth_mode == 2'h2 |-> tx_y_port_e_reg == 8'h00
    && tx_y_port_f_reg == 8'h00; endproperty
  a_m8: assert property (p_m8) else $error("E or F used in 8 bit");
  property p_m10; tx_x_dval_reg && depth_mode == 2'h1 |-> (tx_x_port_b_reg & 8'hcc) == 8'h00
    && (tx_y_port_f_reg & 8'hcc) == 8'h00; endproperty
  a_m10: assert property (p_m10) else $error("unused bit set in 10 bit");
  property p_hold; $changed({tx_x_port_a_reg, tx_x_dval_reg}) |=>
    $stable({tx_x_port_a_reg, tx_x_dval_reg})[*5]; endproperty
  a_hold: assert property (p_hold) else $error("word changed within a pixel");
  property p_start; readout_done && !line_busy_reg |=> line_busy_reg; endproperty
  a_start: assert property (p_start) else $error("line did not start");
  property p_yclk; tx_y_clk_reg == tx_x_clk_reg; endproperty
  a_yclk: assert property (p_yclk) else $error("Y pixel clock differs");
  c_m8: cover property ($rose(tx_x_dval_reg) && depth_mode == 2'h2);
  c_m10: cover property ($rose(tx_x_dval_reg) && depth_mode == 2'h1);
  c_end: cover property ($fell(line_busy_reg));
endmodule // ftlv_chk

bind ftlv_video_out ftlv_chk i_chk (.*);

// file: bench/ftlv_grabber.sv
module ftlv_grabber (
  // Link from transmitters X and Y
  input logic        rx_clk,
  input logic        rx_lval,
  input logic        rx_dval,
  input logic [47:0] rx_ports
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [47:0] rx_q[$];
  // Take a word mid-period, only with both flags high
  always @(negedge rx_clk) if (rx_lval && rx_dval) rx_q.push_back(rx_ports);
endmodule // ftlv_grabber

// file: bench/tb_top.sv
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        sys_clk = 0, reset = 1, pix_clk = 0;
  logic [1:0]  depth_mode;
  logic        model_large, hbin_en, aoi_en, readout_done, sample_valid, sample_ready;
  logic [12:0] aoi_pixels;
  logic [47:0] sample_data;
  logic [7:0]  tx_x_port_a_reg, tx_x_port_b_reg, tx_x_port_c_reg;
  logic [7:0]  tx_y_port_d_reg, tx_y_port_e_reg, tx_y_port_f_reg;
  logic        tx_x_lval_reg, tx_x_dval_reg, tx_x_clk_reg, line_busy_reg;
  int          fail_count = 0;
  int          n_compared = 0;
  int          n_fed;
  logic [31:0] seed = 32'h15f469fb;
  logic [47:0] exp_q[$];

  ftlv_video_out i_dut (.*, .tx_x_fval_reg(), .tx_x_spare_reg(), .tx_y_lval_reg(),
    .tx_y_fval_reg(), .tx_y_dval_reg(), .tx_y_spare_reg(), .tx_y_clk_reg());
  ftlv_grabber i_grab (.rx_clk(tx_x_clk_reg), .rx_lval(tx_x_lval_reg), .rx_dval(tx_x_dval_reg),
    .rx_ports({tx_x_port_a_reg, tx_x_port_b_reg, tx_x_port_c_reg,
               tx_y_port_d_reg, tx_y_port_e_reg, tx_y_port_f_reg}));

  initial forever #4 sys_clk = ~sys_clk;
  initial begin
    #5;
    forever #32 pix_clk = ~pix_clk;
  end

  function automatic logic [31:0] xs(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  // Expected port word {A,B,C,D,E,F} from one sample
  function automatic logic [47:0] map(input logic [1:0] m, input logic [47:0] s);
    logic [11:0] t0, t1, t2, t3;
    t0 = s[11:0] >> (2 * m);
    t1 = s[23:12] >> (2 * m);
    t2 = s[35:24] >> (2 * m);
    t3 = s[47:36] >> (2 * m);
    // Depth code 3 sends all ports zero
    if (m == 2'h3) return 48'h000000000000;
    if (m == 2'h2) return {t0[7:0], t1[7:0], t2[7:0], t3[7:0], 16'h0000};
    return {t0[7:0], t1[11:8], t0[11:8], t1[7:0], t3[7:0], t2[7:0], t3[11:8], t2[11:8]};
  endfunction

  task automatic check(input logic [47:0] got, input logic [47:0] exp);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic report_and_stop;
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic feed(input int n, input logic [1:0] m);
    logic ok;
    for (int i = 0; i < n; i++) begin
      seed = xs(seed);
      sample_data[31:0] = seed;
      seed = xs(seed);
      sample_data[47:32] = seed[15:0];
      sample_valid = 1'b1;
      exp_q.push_back(map(m, sample_data));
      do begin
        ok = sample_ready;
        @(negedge sys_clk);
      end while (!ok);
      n_fed++;
    end
    sample_valid = 1'b0;
  endtask

  task automatic run_line(input logic [1:0] m, input logic lg, input logic hb,
                          input logic ao, input logic [12:0] ap);
    int n;
    int k;
    n = ao ? ap / 4 : (lg ? 1024 : 512) >> hb;
    @(negedge sys_clk);
    depth_mode = m;
    model_large = lg;
    hbin_en = hb;
    aoi_en = ao;
    aoi_pixels = ap;
    n_fed = 0;
    exp_q.delete();
    i_grab.rx_q.delete();
    fork
      feed(n, m);
    join_none
    repeat (48) @(negedge sys_clk);
    check(48'(i_grab.rx_q.size()), 48'd0);
    if (n >= 32) begin
      check(48'(n_fed), 48'd32);
      check(48'(sample_ready), 48'd0);
    end
    readout_done = 1'b1;
    @(negedge sys_clk);
    readout_done = 1'b0;
    for (k = 0; k < 20000 && line_busy_reg !== 1'b0; k++) @(negedge sys_clk);
    check(48'(line_busy_reg), 48'd0);
    repeat (16) @(negedge sys_clk);
    check(48'(i_grab.rx_q.size()), 48'(n));
    while (exp_q.size() > 0 && i_grab.rx_q.size() > 0)
      check(i_grab.rx_q.pop_front(), exp_q.pop_front());
    check(48'(sample_ready), 48'd1);
  endtask

  initial begin
    depth_mode = 2'h0;
    {model_large, hbin_en, aoi_en, readout_done, sample_valid} = 5'h00;
    aoi_pixels = 13'h0000;
    sample_data = 48'h000000000000;
    repeat (5) @(posedge sys_clk);
    @(negedge sys_clk);
    reset = 1'b0;
    for (int m = 0; m < 4; m++) run_line(m[1:0], 1'b0, 1'b0, 1'b1, 13'h0010);
    run_line(2'h1, 1'b0, 1'b1, 1'b0, 13'h0000);
    run_line(2'h0, 1'b0, 1'b0, 1'b0, 13'h0000);
    run_line(2'h2, 1'b1, 1'b1, 1'b0, 13'h0000);
    run_line(2'h0, 1'b1, 1'b0, 1'b0, 13'h0000);
    run_line(2'h1, 1'b0, 1'b0, 1'b1, {5'h01, seed[7:0]});
    report_and_stop;
  end

  initial begin
    #400000;
    fail_count++;
    report_and_stop;
  end
endmodule // tb_top
